// >>> pkg/epc_regs.svh
`ifndef EPC_REGS_SVH
`define EPC_REGS_SVH
// byte addresses on the register bus
`define EPC_OFS_ACMD 5'h00
`define EPC_OFS_DFIFO 5'h04
`define EPC_OFS_ECR 5'h08
`define EPC_OFS_CTRL 5'h0C
`define EPC_OFS_STAT 5'h10
`define EPC_OFS_DATA 5'h14
`define EPC_OFS_THR 5'h18
// extended control fields
`define EPC_ECR_MODE_HI 7
`define EPC_ECR_MODE_LO 5
`define EPC_ECR_FAULT_EN_N 4
`define EPC_ECR_DMA_EN 3
`define EPC_ECR_SVC_MASK 2
// line control fields, a one in bits 0 to 3 asserts the line
`define EPC_CTRL_STROBE 0
`define EPC_CTRL_AFD 1
`define EPC_CTRL_INIT 2
`define EPC_CTRL_SELIN 3
`define EPC_CTRL_ACKIE 4
`define EPC_CTRL_DIR 5
// reset values
`define EPC_MODE_RST 3'h0
`define EPC_FAULT_EN_N_RST 1'h1
`define EPC_DMA_EN_RST 1'h0
`define EPC_SVC_MASK_RST 1'h1
`define EPC_CTRL_RST 6'h00
`define EPC_DATA_RST 8'h00
`define EPC_THR_RST 4'h0
// fifo and service levels
`define EPC_FIFO_DEPTH 5'h10
`define EPC_SVC_TOP 5'h0F
// timing
`define EPC_CLK_MHZ 20
`define EPC_SETUP_NS 500
`define EPC_SETUP_CYC ((`EPC_SETUP_NS * `EPC_CLK_MHZ + 999) / 1000)
`endif

// >>> pkg/epc_pkg.sv
package epc_pkg;
  typedef enum logic [2:0] {
    EPC_MODE_STD = 3'h0,
    EPC_MODE_BIDIR = 3'h1,
    EPC_MODE_FIFO = 3'h2,
    EPC_MODE_ECP = 3'h3,
    EPC_MODE_EPP = 3'h4,
    EPC_MODE_RSVD = 3'h5,
    EPC_MODE_TEST = 3'h6,
    EPC_MODE_CFG = 3'h7
  } epc_mode_t;
  typedef enum logic [2:0] {
    EPC_ST_IDLE = 3'h0,
    EPC_ST_SETUP = 3'h1,
    EPC_ST_STROBE = 3'h3,
    EPC_ST_RELEASE = 3'h2,
    EPC_ST_REV_WAIT = 3'h6,
    EPC_ST_REV_LATCH = 3'h7,
    EPC_ST_RLE_REP = 3'h5
  } epc_state_t;
endpackage : epc_pkg

// >>> hdl/epc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module epc_sync #(
  parameter int W = 13
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
          stage1[i] <= 1'h0;
          sync_out[i] <= 1'h0;
        end else begin
          stage1[i] <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate
endmodule : epc_sync
`default_nettype wire

// >>> hdl/epc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
`include "epc_regs.svh"
module epc_fifo (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // control
  input wire logic flush_in,
  input wire logic push_in,
  input wire logic [8:0] push_data_in,
  input wire logic pop_in,
  // state
  output logic [8:0] head_out,
  output logic [4:0] count_out,
  output logic full_out,
  output logic empty_out
);
  logic [8:0] mem [0:15];
  logic [3:0] wr_ptr;
  logic [3:0] rd_ptr;
  logic do_push;
  logic do_pop;

  assign full_out = (count_out == `EPC_FIFO_DEPTH);
  assign empty_out = (count_out == 5'h00);
  assign do_push = push_in && !full_out;
  assign do_pop = pop_in && !empty_out;
  assign head_out = mem[rd_ptr];

  always_ff @(posedge clk_sys_in) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || flush_in) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      count_out <= 5'h00;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 4'h1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 4'h1;
      end
      if (do_push && !do_pop) begin
        count_out <= count_out + 5'h01;
      end else if (do_pop && !do_push) begin
        count_out <= count_out - 5'h01;
      end
    end
  end
endmodule : epc_fifo
`default_nettype wire

// >>> hdl/epc_port_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "epc_regs.svh"
// Behaviour
// - automatic fifo handshake runs only in fifo and ecp modes, starting on entry
// - leave 000/001 freely, else only back to them; direction changes in 001
// - software drains forward fifo; strobe deasserts as the mode changes, ecp auto-feed one cycle later
// - leaving reverse ecp drops auto-feed one cycle later and discards gathered bytes
// - handshake outputs come from flops so mode changes cause no glitch
// - command port bytes go out as commands, data port bytes as data, forward only
// - direction 1 in ecp mode handshakes each incoming data byte into the fifo; host reads it
// - forward host-ack high means data, low means command; bit 7 picks rle/address
// - reverse peripheral-ack high means data, low means command; address ignored
// - no hardware compression; software writes count then byte
// - received run-length count replicates the next data byte count plus one times
// - four control lines open-drain in mode 000, push-pull otherwise
// - reads stall one cycle, writes never; transfers are single aligned bytes per address
// - service mask set blocks dma and service interrupts; clearing fires pending
// - mask clear with dma enabled interrupts on terminal count
// - mask clear, no dma, direction 0 interrupts while free space meets level
// - mask clear, no dma, direction 1 interrupts while occupancy meets level
// - low fault enable interrupts on fault fall or on enable going 1 to 0 while fault is low
// - acknowledge enable interrupts on each rising acknowledge edge
// - mode is the three-bit field in bits 7 to 5 of extended control
// - both service levels are sixteen minus threshold, threshold programmed less one
module epc_port_ctrl
  import epc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // register bus
  input wire logic [4:0] avm_address_in,
  input wire logic avm_read_in,
  input wire logic avm_write_in,
  input wire logic [31:0] avm_writedata_in,
  input wire logic [3:0] avm_byteenable_in,
  output logic [31:0] avm_readdata_out,
  output logic avm_waitrequest_out,
  // dma
  input wire logic dma_wr_in,
  input wire logic [7:0] dma_wdata_in,
  input wire logic dma_rd_in,
  input wire logic dma_tc_in,
  output logic [7:0] dma_rdata_out,
  output logic dma_req_out,
  // interrupt pulse
  output logic irq_out,
  // port data lines
  input wire logic [7:0] pd_in,
  output logic [7:0] pd_out,
  output logic pd_oe_out,
  // port control lines
  output logic strobe_n_out,
  output logic strobe_n_oe_out,
  output logic auto_feed_n_out,
  output logic auto_feed_n_oe_out,
  output logic init_n_out,
  output logic init_n_oe_out,
  output logic select_in_n_out,
  output logic select_in_n_oe_out,
  // port status lines
  input wire logic ack_n_in,
  input wire logic busy_in,
  input wire logic fault_n_in,
  input wire logic periph_select_in,
  input wire logic paper_end_in
);
  localparam logic [3:0] SETUP_LOAD = 4'(`EPC_SETUP_CYC - 1);

  epc_mode_t mode;
  epc_mode_t mode_req;
  epc_state_t state;
  logic mode_pend;
  logic fault_interrupt_enable_low;
  logic dma_transfer_enable;
  logic service_interrupt_mask;
  logic [5:0] ctrl;
  logic [7:0] spp_data;
  logic [3:0] fifothr;
  logic rd_done;
  logic [7:0] tx_data;
  logic [3:0] timer;
  logic strobe_act;
  logic afd_act;
  logic [7:0] rx_data;
  logic rx_cmd;
  logic rle_on;
  logic [6:0] rle_cnt;
  logic [6:0] rep_left;
  logic [7:0] rep_byte;
  logic ack_n_q;
  logic fault_n_q;
  logic [3:0] line_out;
  logic [3:0] line_oe;
  logic [3:0] line_act;
  logic [12:0] sync_bus;
  logic [7:0] pd_s;
  logic ack_n_s, busy_s, fault_n_s, sel_s, pe_s;
  logic ack_s, fault_s;
  logic [8:0] fifo_head;
  logic [4:0] fifo_count;
  logic fifo_full, fifo_empty;
  logic fifo_push, fifo_pop, fifo_flush, fsm_push, fsm_pop;
  logic [8:0] push_data;
  logic dir, auto_mode, fwd_auto, rev_auto;
  logic wr_en, rd_take, ecr_wr, host_push, dma_push;
  logic [2:0] new_mode;
  logic mode_ok;
  logic [4:0] svc_level;
  logic svc_cond, svc_fire, fault_fire, ack_fire;

  function automatic logic is_plain(input logic [2:0] m);
    is_plain = (m == EPC_MODE_STD) || (m == EPC_MODE_BIDIR);
  endfunction : is_plain

  // active-low lines pass inverted so the synchroniser's reset reads idle,
  // otherwise the edge detectors would see a false edge after reset
  epc_sync #(.W(13)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .async_in({pd_in, !ack_n_in, busy_in, !fault_n_in, periph_select_in,
      paper_end_in}),
    .sync_out(sync_bus)
  );
  assign {pd_s, ack_s, busy_s, fault_s, sel_s, pe_s} = sync_bus;
  assign ack_n_s = !ack_s;
  assign fault_n_s = !fault_s;

  epc_fifo u_fifo (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .flush_in(fifo_flush),
    .push_in(fifo_push),
    .push_data_in(push_data),
    .pop_in(fifo_pop),
    .head_out(fifo_head),
    .count_out(fifo_count),
    .full_out(fifo_full),
    .empty_out(fifo_empty)
  );

  assign dir = ctrl[`EPC_CTRL_DIR];
  assign auto_mode = ((mode == EPC_MODE_FIFO) || (mode == EPC_MODE_ECP)) &&
    !mode_pend;
  assign fwd_auto = auto_mode && !dir;
  assign rev_auto = auto_mode && dir && (mode == EPC_MODE_ECP);

  // reads wait exactly one cycle so read data comes from a flop
  assign avm_waitrequest_out = avm_read_in && !rd_done;
  assign wr_en = avm_write_in && avm_byteenable_in[0];
  assign rd_take = avm_read_in && rd_done;
  assign ecr_wr = wr_en && (avm_address_in == `EPC_OFS_ECR);
  assign new_mode = avm_writedata_in[`EPC_ECR_MODE_HI:`EPC_ECR_MODE_LO];
  assign mode_ok = is_plain(mode) || is_plain(new_mode);

  // the command port is only meaningful going forward in ecp mode
  assign host_push = wr_en && !dir &&
    (((avm_address_in == `EPC_OFS_ACMD) && (mode == EPC_MODE_ECP)) ||
     (avm_address_in == `EPC_OFS_DFIFO));
  assign dma_push = dma_wr_in && !dir && dma_transfer_enable;
  assign push_data = fsm_push ? {1'h0, rep_byte} :
    host_push ? {(avm_address_in == `EPC_OFS_ACMD),
      avm_writedata_in[7:0]} : {1'h0, dma_wdata_in};
  assign fifo_push = fsm_push || host_push || dma_push;
  assign fifo_pop = fsm_pop || (dma_rd_in && dma_transfer_enable) ||
    (rd_take && (avm_address_in == `EPC_OFS_DFIFO) &&
     (dir || (mode == EPC_MODE_TEST)));
  // fifo is held empty in mode 000 and surplus reverse data is dropped
  assign fifo_flush = (mode == EPC_MODE_STD) || (mode_pend && dir);

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      mode <= epc_mode_t'(`EPC_MODE_RST);
      mode_req <= epc_mode_t'(`EPC_MODE_RST);
      mode_pend <= 1'h0;
    end else if (mode_pend) begin
      mode <= mode_req;
      mode_pend <= 1'h0;
    end else if (ecr_wr && mode_ok && (new_mode != mode)) begin
      if (is_plain(mode)) begin
        mode <= epc_mode_t'(new_mode);
      end else begin
        mode_req <= epc_mode_t'(new_mode);
        mode_pend <= 1'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      fault_interrupt_enable_low <= `EPC_FAULT_EN_N_RST;
      dma_transfer_enable <= `EPC_DMA_EN_RST;
    end else if (ecr_wr) begin
      fault_interrupt_enable_low <= avm_writedata_in[`EPC_ECR_FAULT_EN_N];
      dma_transfer_enable <= avm_writedata_in[`EPC_ECR_DMA_EN];
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      service_interrupt_mask <= `EPC_SVC_MASK_RST;
    end else if (svc_fire) begin
      service_interrupt_mask <= 1'h1;
    end else if (ecr_wr) begin
      service_interrupt_mask <= avm_writedata_in[`EPC_ECR_SVC_MASK];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      ctrl <= `EPC_CTRL_RST;
      spp_data <= `EPC_DATA_RST;
      fifothr <= `EPC_THR_RST;
    end else if (wr_en) begin
      if (avm_address_in == `EPC_OFS_CTRL) begin
        ctrl[4:0] <= avm_writedata_in[4:0];
        if (mode == EPC_MODE_BIDIR) begin
          ctrl[`EPC_CTRL_DIR] <= avm_writedata_in[`EPC_CTRL_DIR];
        end
      end else if (avm_address_in == `EPC_OFS_DATA) begin
        spp_data <= avm_writedata_in[7:0];
      end else if (avm_address_in == `EPC_OFS_THR) begin
        fifothr <= avm_writedata_in[3:0];
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      rd_done <= 1'h0;
      avm_readdata_out <= 32'h0000_0000;
    end else begin
      rd_done <= avm_read_in && !rd_done;
      if (avm_read_in && !rd_done) begin
        if (avm_address_in == `EPC_OFS_DFIFO) begin
          avm_readdata_out <= {24'h00_0000, fifo_head[7:0]};
        end else if (avm_address_in == `EPC_OFS_ECR) begin
          avm_readdata_out <= {24'h00_0000, mode, fault_interrupt_enable_low,
            dma_transfer_enable, service_interrupt_mask, fifo_full,
            fifo_empty};
        end else if (avm_address_in == `EPC_OFS_CTRL) begin
          avm_readdata_out <= {26'h000_0000, ctrl};
        end else if (avm_address_in == `EPC_OFS_STAT) begin
          avm_readdata_out <= {24'h00_0000, busy_s, ack_n_s, pe_s, sel_s,
            fault_n_s, 3'h0};
        end else if (avm_address_in == `EPC_OFS_DATA) begin
          // bidirectional mode with direction 1 reads the lines back
          avm_readdata_out <= {24'h00_0000,
            ((mode == EPC_MODE_BIDIR) && dir) ? pd_s : spp_data};
        end else if (avm_address_in == `EPC_OFS_THR) begin
          avm_readdata_out <= {28'h000_0000, fifothr};
        end else begin
          avm_readdata_out <= 32'h0000_0000;
        end
      end
    end
  end

  assign fsm_pop = (state == EPC_ST_IDLE) && fwd_auto && !fifo_empty &&
    !busy_s;
  assign fsm_push = (state == EPC_ST_RLE_REP) ? (rev_auto && !fifo_full) :
    ((state == EPC_ST_REV_LATCH) && rev_auto && ack_n_s && !rx_cmd &&
     !rle_on);

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || !auto_mode) begin
      state <= EPC_ST_IDLE;
      strobe_act <= 1'h0;
      afd_act <= 1'h0;
      rle_on <= 1'h0;
      tx_data <= 8'h00;
      timer <= 4'h0;
      rx_data <= 8'h00;
      rx_cmd <= 1'h0;
      rle_cnt <= 7'h00;
      rep_left <= 7'h00;
      rep_byte <= 8'h00;
    end else begin
      case (state)
        EPC_ST_IDLE: begin
          if (fsm_pop) begin
            tx_data <= fifo_head[7:0];
            afd_act <= fifo_head[8] && (mode == EPC_MODE_ECP);
            timer <= SETUP_LOAD;
            state <= EPC_ST_SETUP;
          end else if (rev_auto && !fifo_full) begin
            afd_act <= 1'h1;
            state <= EPC_ST_REV_WAIT;
          end
        end
        EPC_ST_SETUP: begin
          if (timer == 4'h0) begin
            strobe_act <= 1'h1;
            state <= EPC_ST_STROBE;
          end else begin
            timer <= timer - 4'h1;
          end
        end
        EPC_ST_STROBE: begin
          if (busy_s) begin
            strobe_act <= 1'h0;
            state <= EPC_ST_RELEASE;
          end
        end
        EPC_ST_RELEASE: begin
          if (!busy_s) begin
            afd_act <= 1'h0;
            state <= EPC_ST_IDLE;
          end
        end
        EPC_ST_REV_WAIT: begin
          if (!ack_n_s) begin
            rx_data <= pd_s;
            rx_cmd <= !busy_s;
            afd_act <= 1'h0;
            state <= EPC_ST_REV_LATCH;
          end
        end
        EPC_ST_REV_LATCH: begin
          if (ack_n_s) begin
            state <= EPC_ST_IDLE;
            if (rx_cmd && !rx_data[7]) begin
              rle_cnt <= rx_data[6:0];
              rle_on <= 1'h1;
            end else if (!rx_cmd && rle_on) begin
              rep_byte <= rx_data;
              rep_left <= rle_cnt;
              state <= EPC_ST_RLE_REP;
            end
          end else begin
            rep_byte <= rx_data;
          end
        end
        EPC_ST_RLE_REP: begin
          if (fsm_push) begin
            if (rep_left == 7'h00) begin
              rle_on <= 1'h0;
              state <= EPC_ST_IDLE;
            end else begin
              rep_left <= rep_left - 7'h01;
            end
          end
        end
        default: begin
          state <= EPC_ST_IDLE;
        end
      endcase
    end
  end

  // pins are registered so a mode change never glitches a line
  assign line_act[0] = auto_mode ? strobe_act : ctrl[`EPC_CTRL_STROBE];
  assign line_act[1] = (mode == EPC_MODE_ECP) ? afd_act :
    ctrl[`EPC_CTRL_AFD];
  assign line_act[2] = ctrl[`EPC_CTRL_INIT];
  assign line_act[3] = ctrl[`EPC_CTRL_SELIN];

  genvar li;
  generate
    for (li = 0; li < 4; li++) begin : g_line
      always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
          line_out[li] <= 1'h0;
          line_oe[li] <= 1'h0;
        end else if (mode == EPC_MODE_STD) begin
          line_out[li] <= 1'h0;
          line_oe[li] <= line_act[li];
        end else begin
          line_out[li] <= !line_act[li];
          line_oe[li] <= 1'h1;
        end
      end
    end
  endgenerate

  assign {select_in_n_out, init_n_out, auto_feed_n_out, strobe_n_out} =
    line_out;
  assign {select_in_n_oe_out, init_n_oe_out, auto_feed_n_oe_out,
    strobe_n_oe_out} = line_oe;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      pd_out <= 8'h00;
      pd_oe_out <= 1'h0;
      dma_req_out <= 1'h0;
      dma_rdata_out <= 8'h00;
    end else begin
      pd_out <= auto_mode ? tx_data : spp_data;
      pd_oe_out <= (mode == EPC_MODE_STD) || !dir;
      dma_req_out <= auto_mode && dma_transfer_enable &&
        !service_interrupt_mask && (dir ? !fifo_empty : !fifo_full);
      if (dma_rd_in) begin
        dma_rdata_out <= fifo_head[7:0];
      end
    end
  end

  assign svc_level = `EPC_SVC_TOP - {1'h0, fifothr};
  assign svc_cond = dma_transfer_enable ? dma_tc_in :
    dir ? (fifo_count >= svc_level) :
    ((`EPC_FIFO_DEPTH - fifo_count) >= svc_level);
  assign svc_fire = !service_interrupt_mask && svc_cond;
  assign fault_fire = (!fault_interrupt_enable_low && fault_n_q &&
    !fault_n_s) || (ecr_wr && fault_interrupt_enable_low &&
    !avm_writedata_in[`EPC_ECR_FAULT_EN_N] && !fault_n_s);
  assign ack_fire = ctrl[`EPC_CTRL_ACKIE] && !ack_n_q && ack_n_s;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      ack_n_q <= 1'h1;
      fault_n_q <= 1'h1;
      irq_out <= 1'h0;
    end else begin
      ack_n_q <= ack_n_s;
      fault_n_q <= fault_n_s;
      irq_out <= svc_fire || fault_fire || ack_fire;
    end
  end

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  sequence fwd_start_s;
    fsm_pop;
  endsequence
  sequence setup_hold_s;
    !strobe_act [*8];
  endsequence

  mode_legal_a: assert property ($changed(mode) |->
    is_plain($past(mode)) || is_plain(mode))
    else $error("illegal mode transition");
  dir_change_a: assert property ($changed(dir) |->
    $past(mode) == EPC_MODE_BIDIR)
    else $error("direction changed outside mode 001");
  leave_quiet_a: assert property (mode_pend |=>
    !strobe_act && !afd_act && (state == EPC_ST_IDLE))
    else $error("handshake lines not released on mode exit");
  od_style_a: assert property ($past(mode) == EPC_MODE_STD |->
    line_out == 4'h0)
    else $error("control line pulled high in mode 000");
  pp_style_a: assert property ($past(mode) != EPC_MODE_STD |->
    line_oe == 4'hF)
    else $error("control line not push-pull");
  fwd_setup_a: assert property (fwd_start_s |=>
    setup_hold_s ##[1:4] strobe_act)
    else $error("strobe timing after fifo pop wrong");
  fwd_kind_a: assert property (fwd_start_s |=>
    afd_act == ($past(fifo_head[8]) && (mode == EPC_MODE_ECP)))
    else $error("host-ack level does not match byte kind");
  svc_fire_a: assert property (svc_fire |=>
    service_interrupt_mask && irq_out)
    else $error("service event did not raise interrupt and mask");
  mask_block_a: assert property ($past(service_interrupt_mask) |->
    !dma_req_out)
    else $error("dma requested while service mask set");
  fault_irq_a: assert property ((!fault_interrupt_enable_low && fault_n_q &&
    !fault_n_s) |=> irq_out)
    else $error("fault edge missed");
  ack_irq_a: assert property ((ctrl[`EPC_CTRL_ACKIE] && !ack_n_q &&
    ack_n_s) |=> irq_out)
    else $error("acknowledge edge missed");
  rle_end_a: assert property ((state == EPC_ST_RLE_REP && fsm_push &&
    rep_left == 7'h00 && auto_mode) |=> !rle_on && state == EPC_ST_IDLE)
    else $error("run-length replication did not end");
  bus_wait_a: assert property ((avm_read_in && !rd_done) |=>
    !avm_waitrequest_out)
    else $error("read held off more than one cycle");
endmodule : epc_port_ctrl
`default_nettype wire

// >>> test/epc_periph.sv
`timescale 1ns/1ps
`default_nettype none
module epc_periph #(
  parameter int HOLD = 4
) (
  // clock
  input wire logic clk_sys_in,
  // host lines as seen on the wire
  input wire logic strobe_n_in,
  input wire logic auto_feed_n_in,
  input wire logic [7:0] pd_in,
  // peripheral lines and capture
  output logic busy_out,
  output logic [17:0] rx_out,
  output int rx_cnt_out
);
  int hold;
  initial begin
    busy_out = 1'b0;
    rx_out = '0;
    rx_cnt_out = 0;
    hold = 0;
  end
  // busy stays up a few cycles after strobe rises, like a slow printer
  always @(posedge clk_sys_in) begin
    if (!busy_out && !strobe_n_in) begin
      busy_out <= 1'b1;
      rx_out <= {rx_out[8:0], auto_feed_n_in, pd_in};
      rx_cnt_out <= rx_cnt_out + 1;
      hold <= HOLD;
    end else if (busy_out && strobe_n_in) begin
      if (hold == 0) busy_out <= 1'b0;
      else hold <= hold - 1;
    end
  end
endmodule : epc_periph
`default_nettype wire

// >>> test/epc_port_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "epc_regs.svh"
module epc_port_ctrl_tb;
  logic clk = 0, rstn = 0, rd = 0, wr = 0, tc = 0, fault_n = 1, ack_n = 1;
  logic [4:0] adr = 0;
  logic [31:0] wd = 0, rdata, rdat;
  logic [3:0] be = 0;
  logic wreq, irq, busy, stb, stb_oe, afd, afd_oe, pd_oe;
  logic [7:0] pd_out;
  logic [17:0] rx;
  int rx_cnt, irqs = 0, err_count = 0, num_checks = 0;
  // undriven lines float high through pull-ups
  wire stb_w = stb_oe ? stb : 1'b1;
  wire afd_w = afd_oe ? afd : 1'b1;
  wire [7:0] pd_w = pd_oe ? pd_out : 8'hFF;
  epc_port_ctrl i_dut (.clk_sys_in(clk), .rstn_in(rstn),
    .avm_address_in(adr), .avm_read_in(rd), .avm_write_in(wr),
    .avm_writedata_in(wd), .avm_byteenable_in(be),
    .avm_readdata_out(rdata), .avm_waitrequest_out(wreq),
    .dma_wr_in(1'b0), .dma_wdata_in(8'h00), .dma_rd_in(1'b0),
    .dma_tc_in(tc), .dma_rdata_out(), .dma_req_out(), .irq_out(irq),
    .pd_in(pd_w), .pd_out(pd_out), .pd_oe_out(pd_oe),
    .strobe_n_out(stb), .strobe_n_oe_out(stb_oe),
    .auto_feed_n_out(afd), .auto_feed_n_oe_out(afd_oe),
    .init_n_out(), .init_n_oe_out(), .select_in_n_out(),
    .select_in_n_oe_out(), .ack_n_in(ack_n), .busy_in(busy),
    .fault_n_in(fault_n), .periph_select_in(1'b1), .paper_end_in(1'b0));
  epc_periph i_periph (.clk_sys_in(clk), .strobe_n_in(stb_w),
    .auto_feed_n_in(afd_w), .pd_in(pd_w), .busy_out(busy),
    .rx_out(rx), .rx_cnt_out(rx_cnt));
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (irq === 1'b1) irqs <= irqs + 1;
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // one bus cycle held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wd <= {24'h000000, d};
    be <= 4'hF;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wreq !== 1'b0);
    rdat = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic rdc(input logic [4:0] a, input logic [7:0] e, input string m);
    bus(1'b0, a, 8'h00);
    chk(rdat, {24'h000000, e}, m);
  endtask : rdc
  task automatic irq_win(input int n, input int e, input string m);
    int c0;
    c0 = irqs;
    repeat (n) @(posedge clk);
    chk(irqs - c0, e, m);
  endtask : irq_win
  task automatic t_reset;
    rdc(`EPC_OFS_ECR, 8'h15, "ecr reset");
    rdc(`EPC_OFS_CTRL, 8'h00, "ctrl reset");
    rdc(5'h1C, 8'h00, "unmapped");
  endtask : t_reset
  task automatic t_forward;
    int n;
    bus(1'b1, `EPC_OFS_CTRL, 8'h00);
    bus(1'b1, `EPC_OFS_ECR, 8'h74);
    repeat (3) @(posedge clk);
    chk(stb_oe, 1'b1, "push-pull");
    bus(1'b1, `EPC_OFS_ACMD, 8'h85);
    bus(1'b1, `EPC_OFS_DFIFO, 8'h5A);
    n = 0;
    while (rx_cnt < 2 && n < 600) begin
      @(posedge clk);
      n++;
    end
    chk(rx, {1'b0, 8'h85, 1'b1, 8'h5A}, "cmd then data");
    repeat (40) @(posedge clk);
    rdc(`EPC_OFS_ECR, 8'h75, "drained");
    bus(1'b1, `EPC_OFS_ECR, 8'h54);
    rdc(`EPC_OFS_ECR, 8'h75, "illegal mode");
    bus(1'b1, `EPC_OFS_ECR, 8'h14);
    repeat (3) @(posedge clk);
    chk({stb_w, stb_oe, afd_w}, 3'b101, "lines idle");
  endtask : t_forward
  task automatic t_service;
    bus(1'b1, `EPC_OFS_ECR, 8'h34);
    bus(1'b1, `EPC_OFS_ECR, 8'h30);
    irq_win(4, 1, "service irq");
    rdc(`EPC_OFS_ECR, 8'h35, "mask reset");
  endtask : t_service
  task automatic t_dma;
    bus(1'b1, `EPC_OFS_ECR, 8'h38);
    irq_win(4, 0, "no tc");
    @(posedge clk);
    tc <= 1'b1;
    @(posedge clk);
    tc <= 1'b0;
    irq_win(4, 1, "tc irq");
  endtask : t_dma
  task automatic t_fault;
    bus(1'b1, `EPC_OFS_ECR, 8'h2C);
    @(posedge clk);
    fault_n <= 1'b0;
    irq_win(8, 1, "fault fall");
    bus(1'b1, `EPC_OFS_ECR, 8'h3C);
    bus(1'b1, `EPC_OFS_ECR, 8'h2C);
    irq_win(4, 1, "enable drop");
  endtask : t_fault
  task automatic t_ack;
    bus(1'b1, `EPC_OFS_CTRL, 8'h30);
    rdc(`EPC_OFS_CTRL, 8'h30, "dir in 001");
    rdc(`EPC_OFS_DATA, 8'hFF, "lines read back");
    for (int en = 1; en >= 0; en--) begin
      ack_n <= 1'b0;
      irq_win(6, 0, "ack fall");
      ack_n <= 1'b1;
      irq_win(8, en, "ack rise");
      bus(1'b1, `EPC_OFS_CTRL, 8'h20);
    end
  endtask : t_ack
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_forward();
    t_service();
    t_dma();
    t_fault();
    t_ack();
    give_verdict();
  end
  // the run needs well under 2000 cycles
  initial begin
    #(20000 * 50);
    err_count++;
    give_verdict();
  end
endmodule : epc_port_ctrl_tb
`default_nettype wire
